// ---- logic/sscs_pkg.sv ----
package sscs_pkg;
    localparam int SSCS_WORD_W = 8;
    localparam logic [7:0] SSCS_SHIFT_RST = 8'h00;
    localparam logic [7:0] SSCS_LATCH_RST = 8'h00;
    localparam int SSCS_MSB = 7;
    // Host divider: link clock half period rounded up to whole system clocks (12 here)
    localparam int SSCS_CLK_NS = 20;
    localparam int SSCS_HALF_NS = 240;
    localparam int SSCS_HALF_CYC = (SSCS_HALF_NS + SSCS_CLK_NS - 1) / SSCS_CLK_NS;
    localparam logic [3:0] SSCS_HALF_CNT = 4'(SSCS_HALF_CYC);
    localparam logic [3:0] SSCS_BITS_LAST = 4'h7;
    localparam logic [7:0] SSCS_BITS_MAX = 8'hff;
endpackage

// ---- logic/sscs_if.sv ----
`timescale 1ns/10ps
interface sscs_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    modport dev (input sclk, input cs_n, input din, output dout);
    modport host (output sclk, output cs_n, output din, input dout);
endinterface

// ---- logic/sscs_dev.sv ----
`timescale 1ns/10ps
// Device end: shift and output on the link clock, latch on a strobe from select and clock; the supply-dip reset is the async rstn_i
module sscs_dev
    import sscs_pkg::*;
(
    input wire logic rstn_i,
    sscs_if.dev lnk,
    output logic [7:0] switch_closed_o
);
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic dout_r;
    logic upd_clk;

    // Rising clock shift while selected; switches untouched meanwhile
    always_comb
    begin
        shift_nxt = shift_r;
        if (!lnk.cs_n)
        begin
            shift_nxt = {shift_r[SSCS_MSB-1:0], lnk.din};
        end
    end

    always_ff @(posedge lnk.sclk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            shift_r <= SSCS_SHIFT_RST;
        end
        else
        begin
            shift_r <= shift_nxt;
        end
    end

    // Chain output changes on falling clock, holds while deselected
    always_ff @(negedge lnk.sclk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            dout_r <= 1'b0;
        end
        else if (!lnk.cs_n)
        begin
            dout_r <= shift_r[SSCS_MSB];
        end
    end
    assign lnk.dout = dout_r;

    // Latch strobe: deselected while the clock is low. A select rise during a high
    // clock thus fires at the next clock fall. Clock falls while deselected only
    // reload the frozen register, so the switches keep their state.
    // Select and clock must not change together, or the strobe may glitch.
    assign upd_clk = lnk.cs_n & ~lnk.sclk;
    always_ff @(posedge upd_clk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            switch_closed_o <= SSCS_LATCH_RST;
        end
        else
        begin
            switch_closed_o <= shift_r;
        end
    end
endmodule // sscs_dev

// ---- logic/sscs_host.sv ----
`timescale 1ns/10ps
// Host end: divides clk_i to make the link clock and sends nbits_i bits (word_i, MSB first, then zeros) per start
module sscs_host
    import sscs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [7:0] nbits_i,
    input wire logic [7:0] word_i,
    output logic busy_o,
    output logic [7:0] echo_o,
    sscs_if.host lnk
);
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_LOW = 2'b01, ST_HIGH = 2'b11,
        ST_DONE = 2'b10} sscs_st_t;
    typedef struct packed {
        sscs_st_t st;
        logic [3:0] div;
        logic [7:0] left;
        logic [7:0] data;
        logic [7:0] echo;
        logic sclk;
        logic cs_n;
        logic din;
        logic busy;
        logic [2:0] dsync;
        logic dval;
    } sscs_host_t;
    sscs_host_t s_r;
    sscs_host_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.dsync = {s_r.dsync[1:0], lnk.dout};
        // Filtered chain bit: a disagreeing pair keeps the old value, never drops a bit
        if (s_r.dsync[2] == s_r.dsync[1])
        begin
            s_nxt.dval = s_r.dsync[2];
        end
        unique case (s_r.st)
            ST_IDLE:
            begin
                if (start_i && nbits_i != 8'h00)
                begin
                    s_nxt.st = ST_LOW;
                    s_nxt.cs_n = 1'b0;
                    s_nxt.data = word_i;
                    s_nxt.left = nbits_i;
                    s_nxt.din = word_i[SSCS_MSB];
                    s_nxt.div = 4'h0;
                    s_nxt.busy = 1'b1;
                end
            end
            ST_LOW:
            begin
                s_nxt.div = s_r.div + 4'h1;
                if (s_r.div == SSCS_HALF_CNT - 4'h1)
                begin
                    s_nxt.div = 4'h0;
                    s_nxt.sclk = 1'b1;
                    s_nxt.st = ST_HIGH;
                    s_nxt.echo = {s_r.echo[6:0], s_r.dval};
                end
            end
            ST_HIGH:
            begin
                s_nxt.div = s_r.div + 4'h1;
                if (s_r.div == SSCS_HALF_CNT - 4'h1)
                begin
                    s_nxt.div = 4'h0;
                    s_nxt.sclk = 1'b0;
                    s_nxt.left = s_r.left - 8'h01;
                    s_nxt.data = {s_r.data[6:0], 1'b0};
                    s_nxt.din = s_r.data[SSCS_MSB-1];
                    s_nxt.st = (s_r.left == 8'h01) ? ST_DONE : ST_LOW;
                end
            end
            ST_DONE:
            begin
                s_nxt.div = s_r.div + 4'h1;
                if (s_r.div == SSCS_HALF_CNT - 4'h1)
                begin
                    s_nxt.cs_n = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_r <= '{st: ST_IDLE, div: 4'h0, left: 8'h00, data: 8'h00, echo: 8'h00,
                sclk: 1'b0, cs_n: 1'b1, din: 1'b0, busy: 1'b0, dsync: 3'h0, dval: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign lnk.sclk = s_r.sclk;
    assign lnk.cs_n = s_r.cs_n;
    assign lnk.din = s_r.din;
    assign busy_o = s_r.busy;
    assign echo_o = s_r.echo;
endmodule // sscs_host

// ---- verif/sscs_properties.sv ----
`timescale 1ns/10ps
module sscs_properties (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic [7:0] switch_closed_i
);
    logic [7:0] m_r;
    // Mirror of the device register so dout and the latch can be judged
    always_ff @(posedge sclk or negedge rstn_i)
        if (!rstn_i)
            m_r <= 8'h00;
        else if (!cs_n)
            m_r <= {m_r[6:0], din};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_hold; $changed(switch_closed_i) |-> cs_n; endproperty
    a_hold: assert property (p_hold) else $error("sw moved");
    property p_latch; $rose(cs_n) |-> switch_closed_i == m_r; endproperty
    a_latch: assert property (p_latch) else $error("latch");
    property p_out; !sclk |-> dout == m_r[7]; endproperty
    a_out: assert property (p_out) else $error("dout");
    property p_fall; $changed(dout) |-> $fell(sclk); endproperty
    a_fall: assert property (p_fall) else $error("dout edge");
    property p_quiet; cs_n && $past(cs_n) |-> $stable(dout); endproperty
    a_quiet: assert property (p_quiet) else $error("dout idle");
    property p_din; $changed(din) |-> !sclk; endproperty
    a_din: assert property (p_din) else $error("din");
    property p_rise; $rose(cs_n) |-> !sclk; endproperty
    a_rise: assert property (p_rise) else $error("cs rise");
    property p_idle; cs_n |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("sclk idle");
    c_frame: cover property ($rose(cs_n));
    c_full: cover property (switch_closed_i == 8'h88);
    c_dout: cover property ($rose(dout));
endmodule // sscs_properties

// ---- verif/serial_switch_control_shifter_tb.sv ----
`timescale 1ns/10ps
module serial_switch_control_shifter_tb;
    logic clk_i = 1'b0;
    logic rstn_i;
    logic start_i = 1'b0;
    logic [7:0] nbits_i = 8'h00;
    logic [7:0] word_i = 8'h00;
    logic busy_o;
    logic [7:0] echo_o;
    logic [7:0] sw;
    logic [7:0] sw_b;
    logic b_addr = 1'b0;
    logic b_off = 1'b0;
    logic b_cut = 1'b0;
    logic cut_arm = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    sscs_if i_sscs_if ();
    sscs_host i_sscs_host (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
        .nbits_i(nbits_i), .word_i(word_i), .busy_o(busy_o), .echo_o(echo_o),
        .lnk(i_sscs_if.host));
    sscs_dev i_sscs_dev (.rstn_i(rstn_i), .lnk(i_sscs_if.dev), .switch_closed_o(sw));
    sscs_properties i_sscs_properties (.clk_i(clk_i), .rstn_i(rstn_i),
        .sclk(i_sscs_if.sclk), .cs_n(i_sscs_if.cs_n), .din(i_sscs_if.din),
        .dout(i_sscs_if.dout), .switch_closed_i(sw));
    // Second device: chained behind the first, or on the shared data line with its own select
    sscs_if i_sscs_if_b ();
    assign i_sscs_if_b.sclk = i_sscs_if.sclk;
    assign i_sscs_if_b.cs_n = i_sscs_if.cs_n | b_off | b_cut;
    assign i_sscs_if_b.din = b_addr ? i_sscs_if.din : i_sscs_if.dout;
    sscs_dev i_sscs_dev_b (.rstn_i(rstn_i), .lnk(i_sscs_if_b.dev), .switch_closed_o(sw_b));
    // Once cut_arm is set, deselects the second device from the first link clock high until cut_arm drops
    always @(posedge clk_i)
    begin
        if (!cut_arm)
            b_cut <= 1'b0;
        else if (i_sscs_if.sclk)
            b_cut <= 1'b1;
    end
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value %s exp %h got %h", nm, exp, got);
            fail_count++;
        end
    endtask
    // Busy is read on the falling edge so the launching edge has settled
    task automatic send(input logic [7:0] n, input logic [7:0] w);
        int k;
        @(posedge clk_i);
        start_i <= 1'b1;
        nbits_i <= n;
        word_i <= w;
        @(posedge clk_i);
        start_i <= 1'b0;
        k = 0;
        do
        begin
            @(negedge clk_i);
            k++;
        end
        while (busy_o !== 1'b0 && k < 1000);
        if (k >= 1000)
        begin
            fail_count++;
            summarize();
        end
    endtask
    initial
        forever #10 clk_i = ~clk_i;
    initial
    begin
        rstn_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        chk("sw", 8'h00, sw);
        send(8'h08, 8'ha5);
        chk("sw", 8'ha5, sw);
        send(8'h08, 8'h3c);
        chk("echo", 8'ha5, echo_o);
        send(8'h08, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            send(8'h01, k == 0 ? 8'h80 : 8'h00);
            chk("walk", 8'h01 << k, sw);
        end
        send(8'h04, 8'h80);
        send(8'h04, 8'h80);
        chk("pair", 8'h88, sw);
        send(8'h10, 8'hc3);
        chk("chain_a", 8'h00, sw);
        chk("chain_b", 8'hc3, sw_b);
        @(posedge clk_i);
        b_addr <= 1'b1;
        send(8'h08, 8'h69);
        chk("addr_a", 8'h69, sw);
        chk("addr_b", 8'h69, sw_b);
        @(posedge clk_i);
        b_off <= 1'b1;
        send(8'h08, 8'h96);
        chk("addr_a", 8'h96, sw);
        chk("addr_b", 8'h69, sw_b);
        @(posedge clk_i);
        b_off <= 1'b0;
        cut_arm <= 1'b1;
        send(8'h02, 8'hc0);
        chk("defer_a", 8'h5b, sw);
        chk("defer_b", 8'hd3, sw_b);
        @(posedge clk_i);
        cut_arm <= 1'b0;
        b_addr <= 1'b0;
        @(posedge clk_i);
        rstn_i <= 1'b0;
        @(negedge clk_i);
        chk("rst", 8'h00, sw);
        chk("rst_b", 8'h00, sw_b);
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        send(8'h08, 8'h5a);
        chk("echo", 8'h00, echo_o);
        chk("sw", 8'h5a, sw);
        summarize();
    end
endmodule // serial_switch_control_shifter_tb
